// ### design/mrd_decoder.sv
// Behaviour
// - Data-read copies axis value to read pair
// - Both axes selected: X value returned
// - Command 10h loads logical position
// - Command 11h loads real position
// - Speed readback, zero while stopped
// - Acceleration readback, zero while stopped
// - Drive commands act at once, selected axes
// - Driving flag high while pulses drive
// - In-position check extends driving flag
// - Plus fixed drive: count pulses, count up
// - Minus fixed drive: count pulses, down
// - Plus continuous drive until stop
// - Minus continuous drive until stop
// - Hold defers next drive starts
// - Release starts held, clears finish bits
// - Decelerating stop; no effect when stopped
// - Sudden stop immediately; none when stopped
// - Home command starts origin search
// - Deviation clear command emits clear pulse
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none

module mrd_decoder
  import mrd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  in_position_input,
  input  wire logic [1:0]  ext_stop,
  input  wire logic [1:0]  encoder_up,
  input  wire logic [1:0]  encoder_down,
  output logic      [1:0]  plus_pulse_out,
  output logic      [1:0]  minus_pulse_out,
  output logic      [1:0]  home_search_start,
  output logic             deviation_clear_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic        wr_en;
  logic        rd_en;
  logic        cmd_wr;
  logic [7:0]  cmd_code;
  logic [1:0]  cmd_axes;

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign cmd_wr   = wr_en & (paddr == ADDR_COMMAND);
  assign cmd_code = pwdata[CMD_LSB +: 8];
  assign cmd_axes = pwdata[AXIS_LSB +: 2];

  // Registers that software writes.
  logic [31:0] pulses_q [2];
  logic [15:0] speed_q  [2];
  logic [15:0] init_q   [2];
  logic [15:0] config_q;
  logic [31:0] lp_set_q;
  logic [1:0]  lp_load_q;
  logic [1:0]  lp_load_d;

  // Software-written parameters; pulse count goes to both axes, speeds split by data half (X low, Y high).
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pulses_q[0] <= 32'h0000_0000;
      pulses_q[1] <= 32'h0000_0000;
      speed_q[0]  <= 16'h0001;
      speed_q[1]  <= 16'h0001;
      init_q[0]   <= 16'h0001;
      init_q[1]   <= 16'h0001;
      config_q    <= 16'h0000;
      lp_set_q    <= 32'h0000_0000;
      lp_load_q   <= 2'h0;
    end else begin
      lp_load_q <= lp_load_d;
      if (wr_en) begin
        unique case (paddr)
          ADDR_PULSES: begin
            pulses_q[0] <= pwdata;
            pulses_q[1] <= pwdata;
          end
          ADDR_SPEED: begin
            speed_q[0] <= pwdata[15:0];
            speed_q[1] <= pwdata[31:16];
          end
          ADDR_INIT_SPD: begin
            init_q[0] <= pwdata[15:0];
            init_q[1] <= pwdata[31:16];
          end
          ADDR_CONFIG: config_q <= pwdata[15:0];
          ADDR_LP_SET: lp_set_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Logical position preset is applied to both axes one cycle later.
  always_comb begin
    lp_load_d = 2'h0;
    if (wr_en && paddr == ADDR_LP_SET) begin
      lp_load_d = 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold logic and per-axis command decode.

  logic       hold_q;
  logic [1:0] held_q;
  logic [1:0] held_minus_q;
  logic [1:0] held_fixed_q;
  logic       is_drive;
  logic       is_release;

  assign is_drive   = cmd_wr & (cmd_code >= CMD_FIX_PLUS) & (cmd_code <= CMD_CON_MINUS);
  assign is_release = cmd_wr & (cmd_code == CMD_RELEASE);

  // Hold defers drive starts until release.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_q       <= 1'b0;
      held_q       <= 2'h0;
      held_minus_q <= 2'h0;
      held_fixed_q <= 2'h0;
    end else if (cmd_wr && cmd_code == CMD_HOLD) begin
      hold_q <= 1'b1;
    end else if (is_release) begin
      hold_q <= 1'b0;
      held_q <= 2'h0;
    end else if (is_drive && hold_q) begin
      for (int i = 0; i < 2; i++) begin
        if (cmd_axes[i]) begin
          held_q[i]       <= 1'b1;
          held_minus_q[i] <= cmd_code[0];
          held_fixed_q[i] <= ~cmd_code[1];
        end
      end
    end
  end

  mrd_axcmd_s axcmd [2];

  // Per-axis command strobes, acting on every selected axis together.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      axcmd[i] = '0;
      if (is_drive && !hold_q && cmd_axes[i]) begin
        axcmd[i].start = 1'b1;
        axcmd[i].minus = cmd_code[0];
        axcmd[i].fixed = ~cmd_code[1];
      end else if (is_release && held_q[i]) begin
        axcmd[i].start = 1'b1;
        axcmd[i].minus = held_minus_q[i];
        axcmd[i].fixed = held_fixed_q[i];
      end
      axcmd[i].release_all = is_release;
      axcmd[i].dec_stop = cmd_wr & cmd_axes[i] & (cmd_code == CMD_DEC_STOP);
      axcmd[i].sud_stop = cmd_wr & cmd_axes[i] & (cmd_code == CMD_SUD_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Axis engines.

  mrd_state_e  st_q    [2];
  logic [31:0] left_q  [2];
  logic [7:0]  div_q   [2];
  logic        minus_q [2];
  logic        fixed_q [2];
  logic [31:0] lp_q    [2];
  logic [31:0] rp_q    [2];
  logic [7:0]  fin_q   [2];
  logic        emit    [2];

  for (genvar g = 0; g < 2; g++) begin : g_axis
    logic stop_now;

    // A pulse fires when the divider wraps during drive or decel, but never in
    // the cycle a stop lands, so no pulse leaves the pin after the stop is seen.
    assign emit[g] = (st_q[g] == MRD_DRIVE || st_q[g] == MRD_DECEL) &&
                     div_q[g] == 8'h00 && !stop_now;
    assign stop_now = axcmd[g].sud_stop || ext_stop[g] ||
                      (axcmd[g].dec_stop && speed_q[g] < init_q[g]);

    // Drive state machine.
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        st_q[g]    <= MRD_IDLE;
        left_q[g]  <= 32'h0000_0000;
        div_q[g]   <= 8'h00;
        minus_q[g] <= 1'b0;
        fixed_q[g] <= 1'b0;
      end else begin
        div_q[g] <= (div_q[g] == 8'h00) ? PULSE_DIV - 8'h01 : div_q[g] - 8'h01;
        unique case (st_q[g])
          MRD_IDLE: begin
            if (axcmd[g].start) begin
              st_q[g]    <= MRD_DRIVE;
              left_q[g]  <= pulses_q[g];
              minus_q[g] <= axcmd[g].minus;
              fixed_q[g] <= axcmd[g].fixed;
              div_q[g]   <= 8'h00;
            end
          end
          MRD_DRIVE, MRD_DECEL: begin
            if (stop_now) begin
              st_q[g] <= MRD_INPOS;
            end else if (axcmd[g].dec_stop) begin
              st_q[g] <= MRD_DECEL;
            end else if (emit[g] && (st_q[g] == MRD_DECEL ||
                         (fixed_q[g] && left_q[g] <= 32'h0000_0001))) begin
              st_q[g] <= MRD_INPOS;
            end else if (fixed_q[g] && left_q[g] == 32'h0000_0000) begin
              st_q[g] <= MRD_INPOS;
            end
            if (emit[g] && left_q[g] != 32'h0000_0000) begin
              left_q[g] <= left_q[g] - 32'h0000_0001;
            end
          end
          MRD_INPOS: begin
            if (!config_q[CFG_INPOS_EN_X + g] || in_position_input[g]) begin
              st_q[g] <= MRD_IDLE;
            end
          end
        endcase
      end
    end

    // Logical position follows emitted pulses; real follows the encoder.
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        lp_q[g] <= 32'h0000_0000;
        rp_q[g] <= 32'h0000_0000;
      end else begin
        if (lp_load_q[g]) begin
          lp_q[g] <= lp_set_q;
        end else if (emit[g] && (!fixed_q[g] || left_q[g] != 32'h0000_0000)) begin
          lp_q[g] <= minus_q[g] ? lp_q[g] - 32'h0000_0001
                                : lp_q[g] + 32'h0000_0001;
        end
        if (encoder_up[g] && !encoder_down[g]) begin
          rp_q[g] <= rp_q[g] + 32'h0000_0001;
        end else if (encoder_down[g] && !encoder_up[g]) begin
          rp_q[g] <= rp_q[g] - 32'h0000_0001;
        end
      end
    end

    // Pulse pins high for one clock of each PULSE_DIV period.
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        plus_pulse_out[g]  <= 1'b0;
        minus_pulse_out[g] <= 1'b0;
      end else begin
        plus_pulse_out[g]  <= emit[g] && !minus_q[g] && !(fixed_q[g] && left_q[g] == 32'h0);
        minus_pulse_out[g] <= emit[g] && minus_q[g] && !(fixed_q[g] && left_q[g] == 32'h0);
      end
    end

    // Finish status records the last stop that ended a drive at once; set wins over clear.
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        fin_q[g] <= 8'h00;
      end else if ((st_q[g] == MRD_DRIVE || st_q[g] == MRD_DECEL) && stop_now) begin
        fin_q[g] <= {6'h00, ext_stop[g], axcmd[g].sud_stop | axcmd[g].dec_stop};
      end else if (axcmd[g].release_all) begin
        fin_q[g] <= 8'h00;
      end
    end

    // Home search start pulse.
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        home_search_start[g] <= 1'b0;
      end else begin
        home_search_start[g] <= cmd_wr && cmd_axes[g] && cmd_code == CMD_HOME;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Home error bit, cleared by release.

  logic [1:0] home_err_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      home_err_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (home_search_start[i] && ext_stop[i]) begin
          home_err_q[i] <= 1'b1;
        end else if (is_release) begin
          home_err_q[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deviation clear pulse generator.

  logic [7:0] dcc_cnt_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dcc_cnt_q           <= 8'h00;
      deviation_clear_pin <= 1'b0;
    end else begin
      if (cmd_wr && cmd_code == CMD_DEV_CLR && config_q[CFG_DCC_EN]) begin
        dcc_cnt_q <= (config_q[CFG_DCC_WID +: 8] == 8'h00) ? 8'h01
                     : config_q[CFG_DCC_WID +: 8];
      end else if (dcc_cnt_q != 8'h00) begin
        dcc_cnt_q <= dcc_cnt_q - 8'h01;
      end
      deviation_clear_pin <= config_q[CFG_DCC_LEVEL] ^ (dcc_cnt_q == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-read commands and read pair.

  logic [31:0] rdata_q;
  logic        rsel;
  logic        axsel_q;

  assign rsel = ~cmd_axes[0] & cmd_axes[1];

  // Status reads follow the axis of the last command, not live bus data.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      axsel_q <= 1'b0;
    end else if (cmd_wr) begin
      axsel_q <= rsel;
    end
  end

  // Selected value latched into the read pair.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (cmd_wr) begin
      unique case (cmd_code)
        CMD_RD_LP: rdata_q <= lp_q[rsel];
        CMD_RD_RP: rdata_q <= rp_q[rsel];
        CMD_RD_SPEED: rdata_q <= (st_q[rsel] == MRD_DRIVE || st_q[rsel] == MRD_DECEL)
                                 ? {16'h0000, speed_q[rsel]} : 32'h0000_0000;
        CMD_RD_ACCEL: rdata_q <= {16'h0000, ACCEL_IDLE};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read mux; zero-wait, unmapped reads return zero with error.

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ADDR_MAIN_STAT: prdata <= {30'h0, st_q[1] != MRD_IDLE,
                                     st_q[0] != MRD_IDLE};
          ADDR_STAT1:   prdata <= {16'h0, fin_q[axsel_q], 8'h00};
          ADDR_STAT2:   prdata <= {24'h0, home_err_q[axsel_q], 7'h00};
          ADDR_RD_LOW:  prdata <= {16'h0, rdata_q[15:0]};
          ADDR_RD_HIGH: prdata <= {16'h0, rdata_q[31:16]};
          ADDR_CONFIG:  prdata <= {16'h0, config_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### common/mrd_pkg.sv
`default_nettype none

package mrd_pkg;

  // APB register byte offsets.
  localparam logic [7:0] ADDR_COMMAND   = 8'h00;
  localparam logic [7:0] ADDR_MAIN_STAT = 8'h04;
  localparam logic [7:0] ADDR_STAT1     = 8'h08;
  localparam logic [7:0] ADDR_STAT2     = 8'h0c;
  localparam logic [7:0] ADDR_RD_LOW    = 8'h10;
  localparam logic [7:0] ADDR_RD_HIGH   = 8'h14;
  localparam logic [7:0] ADDR_PULSES    = 8'h18;
  localparam logic [7:0] ADDR_CONFIG    = 8'h1c;
  localparam logic [7:0] ADDR_SPEED     = 8'h20;
  localparam logic [7:0] ADDR_INIT_SPD  = 8'h24;
  localparam logic [7:0] ADDR_LP_SET    = 8'h28;

  // Command codes.
  localparam logic [7:0] CMD_RD_LP     = 8'h10;
  localparam logic [7:0] CMD_RD_RP     = 8'h11;
  localparam logic [7:0] CMD_RD_SPEED  = 8'h12;
  localparam logic [7:0] CMD_RD_ACCEL  = 8'h13;
  localparam logic [7:0] CMD_FIX_PLUS  = 8'h20;
  localparam logic [7:0] CMD_FIX_MINUS = 8'h21;
  localparam logic [7:0] CMD_CON_PLUS  = 8'h22;
  localparam logic [7:0] CMD_CON_MINUS = 8'h23;
  localparam logic [7:0] CMD_HOLD      = 8'h24;
  localparam logic [7:0] CMD_RELEASE   = 8'h25;
  localparam logic [7:0] CMD_DEC_STOP  = 8'h26;
  localparam logic [7:0] CMD_SUD_STOP  = 8'h27;
  localparam logic [7:0] CMD_HOME      = 8'h62;
  localparam logic [7:0] CMD_DEV_CLR   = 8'h63;

  // Command word fields.
  localparam int CMD_LSB  = 0;
  localparam int AXIS_LSB = 8;

  // Config and status register field positions and widths.
  localparam int CFG_INPOS_EN_X = 0;
  localparam int CFG_INPOS_EN_Y = 1;
  localparam int CFG_DCC_EN     = 2;
  localparam int CFG_DCC_LEVEL  = 3;
  localparam int CFG_DCC_WID    = 8;
  localparam int STAT2_HOME_ERR = 7;
  localparam int FIN_LSB        = 8;
  localparam int HOME_CNT_W     = 4;

  // Pulse period: one pulse every PULSE_DIV clocks.
  localparam logic [7:0] PULSE_DIV   = 8'h04;
  localparam logic [7:0] PULSE_HIGH  = 8'h02;
  localparam logic [15:0] ACCEL_IDLE = 16'h0000;

  // Command access time, 250 ns at 20 MHz.
  localparam int ACCESS_NS = 250;
  localparam int CLK_NS    = 50;
  localparam int ACCESS_CYCLES = ACCESS_NS / CLK_NS;

  // Drive states.
  typedef enum logic [1:0] {
    MRD_IDLE  = 2'b00,
    MRD_DRIVE = 2'b01,
    MRD_DECEL = 2'b11,
    MRD_INPOS = 2'b10
  } mrd_state_e;

  // Decoded command carried to each axis.
  typedef struct packed {
    logic       start;
    logic       minus;
    logic       fixed;
    logic       dec_stop;
    logic       sud_stop;
    logic       release_all;
  } mrd_axcmd_s;

endpackage

`default_nettype wire

// ### test/mrd_host.sv
`timescale 1ns/1ps
`default_nettype none

module mrd_host
  import mrd_pkg::*;
(
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus starts idle.
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; a released bus shows inverted values so stale data is never trusted.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge clock);
  endtask

  // Writes a command word, then keeps the bus quiet for the access time.
  task automatic cmd(input logic [7:0] c, input logic [1:0] ax);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, ADDR_COMMAND, {22'h0, ax, c}, q, e);
    repeat (ACCESS_CYCLES) @(posedge clock);
  endtask
endmodule

`default_nettype wire

// ### test/mrd_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module mrd_asserts
  import mrd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [1:0]  in_position_input,
  input  wire logic [1:0]  ext_stop,
  input  wire logic [1:0]  encoder_up,
  input  wire logic [1:0]  encoder_down,
  input  wire logic [1:0]  plus_pulse_out,
  input  wire logic [1:0]  minus_pulse_out,
  input  wire logic [1:0]  home_search_start,
  input  wire logic        deviation_clear_pin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic hold_q;

  // Tracks hold so that start checks skip deferred drives.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == ADDR_COMMAND) begin
      if (pwdata[7:0] == CMD_HOLD) hold_q <= 1'b1;
      else if (pwdata[7:0] == CMD_RELEASE) hold_q <= 1'b0;
    end
  end

  sequence s_cmd(c, b);
    psel && penable && pwrite && paddr == ADDR_COMMAND && pwdata[7:0] == c
      && pwdata[AXIS_LSB + b];
  endsequence

  property p_ready_next; psel && !penable |=> pready; endproperty
  property p_ready_idle; !psel |=> !pready; endproperty
  property p_err_unmapped;
    psel && !penable && !pwrite && paddr > ADDR_LP_SET |=> pslverr && prdata == 32'h0;
  endproperty
  property p_plus_gap; plus_pulse_out[0] |=> !plus_pulse_out[0] [*3]; endproperty
  property p_minus_gap; minus_pulse_out[0] |=> !minus_pulse_out[0] [*3]; endproperty
  property p_ext_stop;
    ext_stop[0] ##1 ext_stop[0] |-> !plus_pulse_out[0] && !minus_pulse_out[0];
  endproperty
  property p_con_start;
    s_cmd(CMD_CON_PLUS, 0) ##0 (!hold_q && !ext_stop[0]) |-> ##[1:10] plus_pulse_out[0];
  endproperty
  property p_sud_stop;
    s_cmd(CMD_SUD_STOP, 0) |-> ##2 (!plus_pulse_out[0] && !minus_pulse_out[0]) [*8];
  endproperty
  property p_home;
    s_cmd(CMD_HOME, 1) ##0 !ext_stop[1] |-> ##[1:3] home_search_start[1];
  endproperty

  a_ready_next: assert property (p_ready_next) else $error("pready missing after setup");
  a_ready_idle: assert property (p_ready_idle) else $error("pready without select");
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped read not refused");
  a_plus_gap: assert property (p_plus_gap) else $error("plus pulses too close");
  a_minus_gap: assert property (p_minus_gap) else $error("minus pulses too close");
  a_ext_stop: assert property (p_ext_stop) else $error("pulse during stop input");
  a_con_start: assert property (p_con_start) else $error("drive did not start");
  a_sud_stop: assert property (p_sud_stop) else $error("pulse after sudden stop");
  a_home: assert property (p_home) else $error("home start pulse missing");
endmodule

bind mrd_decoder mrd_asserts u_chk (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_position_input(in_position_input), .ext_stop(ext_stop), .encoder_up(encoder_up),
  .encoder_down(encoder_down), .plus_pulse_out(plus_pulse_out),
  .minus_pulse_out(minus_pulse_out), .home_search_start(home_search_start),
  .deviation_clear_pin(deviation_clear_pin)
);

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import mrd_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, dcc, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  inpos = 2'b00, stop = 2'b00, eup = 2'b00, edn = 2'b00;
  logic [1:0]  pp, pm, hs;
  int          err_count = 0, cmp_count = 0, n, nhome = 0, ndcc = 0;
  int          np [2] = '{0, 0};
  int          nm [2] = '{0, 0};

  // Clock of 50 ns period.
  always #25 clock = ~clock;

  mrd_host u_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  mrd_decoder u_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_position_input(inpos), .ext_stop(stop), .encoder_up(eup),
    .encoder_down(edn), .plus_pulse_out(pp), .minus_pulse_out(pm),
    .home_search_start(hs), .deviation_clear_pin(dcc));

  // Counts output pulses and clear-pulse cycles.
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      np[i] += (pp[i] === 1'b1);
      nm[i] += (pm[i] === 1'b1);
    end
    nhome += (hs[1] === 1'b1);
    ndcc  += (dcc === 1'b1);
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm_s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm_s, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string s);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(s, x, q & m);
  endtask

  // Issues a read command and joins the two halves of the read pair.
  task automatic pair(input logic [7:0] c, input logic [1:0] ax, input logic [31:0] x,
                      input string s);
    logic [31:0] lo;
    u_host.cmd(c, ax);
    u_host.xfer(1'b0, ADDR_RD_LOW, 32'h0, lo, e);
    u_host.xfer(1'b0, ADDR_RD_HIGH, 32'h0, q, e);
    chk(s, x, {q[15:0], lo[15:0]});
  endtask

  // Polls the driving flags until both axes are idle.
  task automatic settle();
    repeat (60) begin
      u_host.xfer(1'b0, ADDR_MAIN_STAT, 32'h0, q, e);
      if (q[1:0] === 2'b00) break;
    end
  endtask

  // Watchdog cuts a hang short.
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    finish_test();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(ADDR_MAIN_STAT, 32'h3, 32'h0, "drive flags at reset");
    u_host.xfer(1'b0, 8'h3c, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    wr(ADDR_LP_SET, 32'hfffffffe);
    wr(ADDR_SPEED, 32'h00100010);
    wr(ADDR_INIT_SPD, 32'h00080008);
    wr(ADDR_PULSES, 32'h5);
    pair(CMD_RD_LP, 2'b01, 32'hfffffffe, "negative position");
    u_host.cmd(CMD_FIX_PLUS, 2'b11);
    rd(ADDR_MAIN_STAT, 32'h3, 32'h3, "both driving");
    settle();
    chk("plus count x", 32'd5, 32'(np[0]));
    chk("plus count y", 32'd5, 32'(np[1]));
    pair(CMD_RD_LP, 2'b10, 32'h3, "position y");
    wr(ADDR_PULSES, 32'h3);
    u_host.cmd(CMD_FIX_MINUS, 2'b01);
    settle();
    chk("minus count x", 32'd3, 32'(nm[0]));
    pair(CMD_RD_LP, 2'b11, 32'h0, "both selected");
    pair(CMD_RD_SPEED, 2'b01, 32'h0, "speed stopped");
    pair(CMD_RD_ACCEL, 2'b01, {16'h0, ACCEL_IDLE}, "accel stopped");
    for (int i = 0; i < 5; i++) begin
      eup <= (i < 4) ? 2'b01 : 2'b00;
      edn <= (i < 4) ? 2'b00 : 2'b01;
      @(posedge clock);
      eup <= 2'b00;
      edn <= 2'b00;
      @(posedge clock);
    end
    pair(CMD_RD_RP, 2'b01, 32'h3, "real position");
    u_host.cmd(CMD_CON_PLUS, 2'b01);
    repeat (40) @(posedge clock);
    pair(CMD_RD_SPEED, 2'b01, 32'h10, "speed driving");
    u_host.cmd(CMD_SUD_STOP, 2'b01);
    n = np[0];
    repeat (20) @(posedge clock);
    chk("after sudden stop", 32'(n), 32'(np[0]));
    u_host.cmd(CMD_CON_PLUS, 2'b01);
    repeat (20) @(posedge clock);
    u_host.cmd(CMD_DEC_STOP, 2'b01);
    settle();
    n = np[0];
    u_host.cmd(CMD_DEC_STOP, 2'b01);
    u_host.cmd(CMD_SUD_STOP, 2'b01);
    repeat (20) @(posedge clock);
    chk("stops on idle axis", 32'(n), 32'(np[0]));
    u_host.cmd(CMD_CON_MINUS, 2'b01);
    repeat (20) @(posedge clock);
    stop <= 2'b01;
    repeat (4) @(posedge clock);
    n = nm[0];
    repeat (20) @(posedge clock);
    chk("external stop", 32'(n), 32'(nm[0]));
    rd(ADDR_STAT1, 32'h200, 32'h200, "stop finish bit");
    u_host.cmd(CMD_HOME, 2'b01);
    rd(ADDR_STAT2, 32'h80, 32'h80, "home error bit");
    stop <= 2'b00;
    u_host.cmd(CMD_RELEASE, 2'b01);
    rd(ADDR_STAT1, 32'hff00, 32'h0, "finish bits cleared");
    rd(ADDR_STAT2, 32'h80, 32'h0, "home error cleared");
    u_host.cmd(CMD_HOLD, 2'b01);
    wr(ADDR_PULSES, 32'h2);
    u_host.cmd(CMD_FIX_PLUS, 2'b01);
    n = np[0];
    repeat (20) @(posedge clock);
    chk("held drive", 32'(n), 32'(np[0]));
    u_host.cmd(CMD_RELEASE, 2'b01);
    settle();
    chk("released drive", 32'(n + 2), 32'(np[0]));
    wr(ADDR_CONFIG, 32'h1);
    u_host.cmd(CMD_FIX_PLUS, 2'b01);
    repeat (30) @(posedge clock);
    rd(ADDR_MAIN_STAT, 32'h1, 32'h1, "waits in position");
    inpos <= 2'b01;
    repeat (3) @(posedge clock);
    rd(ADDR_MAIN_STAT, 32'h1, 32'h0, "in position done");
    u_host.cmd(CMD_HOME, 2'b10);
    chk("home start y", 32'd1, 32'(nhome));
    wr(ADDR_SPEED, 32'h00040004);
    u_host.cmd(CMD_CON_PLUS, 2'b01);
    repeat (10) @(posedge clock);
    u_host.cmd(CMD_DEC_STOP, 2'b01);
    rd(ADDR_STAT1, 32'h300, 32'h100, "slow decel stops at once");
    wr(ADDR_CONFIG, 32'h0000030c);
    repeat (4) @(posedge clock);
    ndcc = 0;
    u_host.cmd(CMD_DEV_CLR, 2'b01);
    repeat (10) @(posedge clock);
    chk("clear pulse width", 32'd3, 32'(ndcc));
    finish_test();
  end
endmodule

`default_nettype wire
